/* File: src/fpexc_unit.sv */
// floating-point exception detect and respond unit
// assumes the datapath presents one classified, rounded operation per valid cycle
// and that software reaches the control/status word over a plain register port
//
// What this block does
// - masked invalid: set invalid flag, deliver quiet nan to destination
// - unmasked invalid: set invalid flag, leave operands, request handler
// - masked denormal operand: set denormal flag, continue normally
// - unmasked denormal operand: set denormal flag, keep operands, request handler
// - divide-by-zero when finite non-zero dividend divided by zero divisor
// - masked divide-by-zero: set flag, return infinity with xor of operand signs
// - unmasked divide-by-zero: set flag, leave operands, request handler
// - overflow when rounded magnitude at or above 2^128, 2^1024, 2^16384
// - masked overflow: set flag, result chosen from rounding mode and sign
// - unmasked overflow: flag, handler; simd untouched, stack stores biased result
// - tiny when rounded magnitude below 2^-126, 2^-1022, 2^-16382
// - masked underflow: flag only if tiny and inexact; always deliver denormal
// - unmasked underflow: report any tiny result; simd untouched, stack biased; handler
// - inexact when result not exactly representable in destination format
// - inexact masked alone: set precision flag, store rounded result
// - inexact unmasked alone: set precision flag, store rounded, request handler
// - inexact with masked over/underflow: both flags, that result, handler if unmasked
// - inexact with unmasked over/underflow to register: both flags, result, handler
// - unmasked over/underflow on memory store: no inexact report, clear cc bit one
// - all six flags sticky until software clears them
// - rounding field: 00 nearest, 01 down, 10 up, 11 toward zero
// - control/status word: flags in bits 0..5, masks in bits 7..12
//
// The address-and-strobe port and the register offsets were decided locally.
`default_nettype none
module fpexc_unit
    import fpexc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              I_CLK,
    input  wire logic              I_SYS_RST,
    input  wire fpexc_op_t         I_OP,
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic [31:0]            O_RDATA,
    output fpexc_rsp_t             O_RSP,
    output logic [1:0]             O_ROUND_MODE,
    output logic [5:0]             O_FLAGS,
    output logic                   O_TRAP_REQ
);

    // ========================================================================
    // state
    // ========================================================================
    logic [5:0]  flags;        // sticky exception flags
    logic [5:0]  masks;        // a set bit masks its exception
    fpexc_rnd_t  rnd;          // rounding control field
    logic [5:0]  last_raised;  // exceptions of the last valid operation
    logic [5:0]  next_flags;
    logic [31:0] next_rdata;
    fpexc_rsp_t  next_rsp;
    logic [5:0]  next_raised;
    logic        wr_csr;
    logic        wr_clr;
    logic        rd_csr;
    logic        rd_stat;

    // threshold lookup used for the overflow check, tny_exp below serves the tiny check
    function automatic logic signed [17:0] ovf_exp(input logic [1:0] fmt);
        unique case (fmt)
            FPEXC_FMT_SINGLE: ovf_exp = FPEXC_OVF_SGL;
            FPEXC_FMT_DOUBLE: ovf_exp = FPEXC_OVF_DBL;
            default:          ovf_exp = FPEXC_OVF_EXT;
        endcase
    endfunction

    function automatic logic signed [17:0] tny_exp(input logic [1:0] fmt);
        unique case (fmt)
            FPEXC_FMT_SINGLE: tny_exp = FPEXC_TNY_SGL;
            FPEXC_FMT_DOUBLE: tny_exp = FPEXC_TNY_DBL;
            default:          tny_exp = FPEXC_TNY_EXT;
        endcase
    endfunction

    // true when the port address selects the given register
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [3:0]        reg_addr);
        addr_hit = (addr == ADDR_W'(reg_addr));
    endfunction

    // strobes qualified by the register that they select
    assign wr_csr  = I_WR && addr_hit(I_ADDR, FPEXC_ADDR_CSR);
    assign wr_clr  = I_WR && addr_hit(I_ADDR, FPEXC_ADDR_CLEAR);
    assign rd_csr  = I_RD && addr_hit(I_ADDR, FPEXC_ADDR_CSR);
    assign rd_stat = I_RD && addr_hit(I_ADDR, FPEXC_ADDR_STAT);

    // ========================================================================
    // detection and response selection
    // ========================================================================
    // classify the operation and pick the destination action
    always_comb begin
        logic det_inv;
        logic det_den;
        logic det_zdv;
        logic det_ovf;
        logic det_tny;
        logic det_inx;
        logic rep_unf;
        logic rep_inx;
        logic unm_post;
        det_inv     = I_OP.invalid_op;
        det_den     = I_OP.a_denorm || I_OP.b_denorm;
        det_zdv     = I_OP.is_div && I_OP.a_finite && !I_OP.a_zero && I_OP.b_zero;
        det_ovf     = !I_OP.res_zero && (I_OP.res_exp >= ovf_exp(I_OP.fmt));
        det_tny     = !I_OP.res_zero && (I_OP.res_exp < tny_exp(I_OP.fmt));
        det_inx     = I_OP.res_inexact;
        // masked underflow needs tiny and inexact, unmasked any tiny
        rep_unf     = det_tny && (masks[FPEXC_B_UNF] ? det_inx : 1'b1);
        unm_post    = (det_ovf && !masks[FPEXC_B_OVF]) || (rep_unf && !masks[FPEXC_B_UNF]);
        // a memory store with unmasked over/underflow drops the inexact report
        rep_inx     = det_inx && !(unm_post && I_OP.is_store);
        next_raised = '0;
        next_raised[FPEXC_B_INV] = det_inv;
        next_raised[FPEXC_B_DEN] = det_den;
        next_raised[FPEXC_B_ZDV] = det_zdv;
        next_raised[FPEXC_B_OVF] = det_ovf;
        next_raised[FPEXC_B_UNF] = rep_unf;
        next_raised[FPEXC_B_PRC] = rep_inx;

        next_rsp          = '0;
        next_rsp.valid    = I_OP.valid;
        next_rsp.raised   = I_OP.valid ? next_raised : '0;
        next_rsp.res_sign = I_OP.res_sign;
        next_rsp.res_sel  = FPEXC_RES_ROUNDED;
        next_rsp.clr_cc1  = I_OP.valid && unm_post && I_OP.is_store;
        // any reported exception whose mask is clear asks for the handler
        next_rsp.trap_req = I_OP.valid && |(next_raised & ~masks);
        if (det_inv) begin
            next_rsp.res_sel = masks[FPEXC_B_INV] ? FPEXC_RES_QNAN : FPEXC_RES_NONE;
        end else if (det_den && !masks[FPEXC_B_DEN]) begin
            next_rsp.res_sel = FPEXC_RES_NONE;
        end else if (det_zdv) begin
            next_rsp.res_sign = I_OP.a_sign ^ I_OP.b_sign;
            next_rsp.res_sel  = masks[FPEXC_B_ZDV] ? FPEXC_RES_INF : FPEXC_RES_NONE;
        end else if (det_ovf) begin
            if (!masks[FPEXC_B_OVF]) begin
                next_rsp.res_sel = I_OP.is_stack ? FPEXC_RES_BIASED : FPEXC_RES_NONE;
            end else begin
                // masked overflow result by rounding mode and sign
                unique case (rnd)
                    FPEXC_RND_NEAREST: next_rsp.res_sel = FPEXC_RES_INF;
                    FPEXC_RND_DOWN:    next_rsp.res_sel = I_OP.res_sign ?
                                           FPEXC_RES_INF : FPEXC_RES_MAXFIN;
                    FPEXC_RND_UP:      next_rsp.res_sel = I_OP.res_sign ?
                                           FPEXC_RES_MAXFIN : FPEXC_RES_INF;
                    FPEXC_RND_ZERO:    next_rsp.res_sel = FPEXC_RES_MAXFIN;
                endcase
            end
        end else if (det_tny) begin
            if (!masks[FPEXC_B_UNF]) begin
                next_rsp.res_sel = I_OP.is_stack ? FPEXC_RES_BIASED : FPEXC_RES_NONE;
            end else begin
                next_rsp.res_sel = FPEXC_RES_DENORM;
            end
        end
    end

    // ========================================================================
    // sticky flags
    // ========================================================================
    // software image after this cycle's write, new events on top so a set wins
    always_comb begin
        if (wr_csr) begin
            next_flags = I_WDATA[FPEXC_FLAG_LSB +: FPEXC_NUM_EXC] | next_rsp.raised;
        end else if (wr_clr) begin
            next_flags = (flags & ~I_WDATA[FPEXC_FLAG_LSB +: FPEXC_NUM_EXC])
                         | next_rsp.raised;
        end else begin
            next_flags = flags | next_rsp.raised;
        end
    end

    // flags fall only by reset or by software
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            flags <= FPEXC_FLAG_RST;
        end else begin
            flags <= next_flags;
        end
    end

    // ========================================================================
    // masks and rounding control
    // ========================================================================
    // masks written by software, all masked after reset
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            masks <= FPEXC_MASK_RST;
        end else if (wr_csr) begin
            masks <= I_WDATA[FPEXC_MASK_LSB +: FPEXC_NUM_EXC];
        end
    end

    // rounding control written by software, nearest after reset
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rnd <= FPEXC_RND_NEAREST;
        end else if (wr_csr) begin
            rnd <= fpexc_rnd_t'(I_WDATA[FPEXC_RC_LSB +: FPEXC_RC_W]);
        end
    end

    // ========================================================================
    // status and read port
    // ========================================================================
    // remembers the exceptions of the last valid operation
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            last_raised <= FPEXC_FLAG_RST;
        end else if (I_OP.valid) begin
            last_raised <= next_raised;
        end
    end

    // word of the selected register, zero for any other address
    always_comb begin
        next_rdata = FPEXC_ZERO32;
        if (rd_csr) begin
            next_rdata[FPEXC_FLAG_LSB +: FPEXC_NUM_EXC] = flags;
            next_rdata[FPEXC_MASK_LSB +: FPEXC_NUM_EXC] = masks;
            next_rdata[FPEXC_RC_LSB +: FPEXC_RC_W]      = rnd;
        end else if (rd_stat) begin
            next_rdata[FPEXC_FLAG_LSB +: FPEXC_NUM_EXC] = last_raised;
        end
    end

    // read data stand in the cycle after the read strobe only
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_RDATA <= FPEXC_ZERO32;
        end else begin
            O_RDATA <= next_rdata;
        end
    end

    // ========================================================================
    // registered response to the datapath
    // ========================================================================
    // response for the operation of the previous cycle
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_RSP <= '0;
        end else begin
            O_RSP <= next_rsp;
        end
    end

    // handler request, one pulse per trapping operation
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_TRAP_REQ <= 1'b0;
        end else begin
            O_TRAP_REQ <= next_rsp.trap_req;
        end
    end

    // flag image with this cycle's writes and events already applied
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_FLAGS <= FPEXC_FLAG_RST;
        end else begin
            O_FLAGS <= next_flags;
        end
    end

    // rounding control as the next operation will use it
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_ROUND_MODE <= FPEXC_RND_NEAREST;
        end else begin
            O_ROUND_MODE <= wr_csr ? I_WDATA[FPEXC_RC_LSB +: FPEXC_RC_W] : rnd;
        end
    end

endmodule
`default_nettype wire

/* File: src/fpexc_pkg.sv */
// package for the floating-point exception detect and respond unit
// assumes one clock domain and a register port with one-cycle read data
`default_nettype none
package fpexc_pkg;
    // register addresses on the plain port
    localparam logic [3:0] FPEXC_ADDR_CSR   = 4'h0; // flags, masks, rounding control
    localparam logic [3:0] FPEXC_ADDR_STAT  = 4'h1; // last-operation status
    localparam logic [3:0] FPEXC_ADDR_CLEAR = 4'h2; // write ones to clear flags

    // field positions in the simd control/status register
    localparam int FPEXC_FLAG_LSB = 0;
    localparam int FPEXC_MASK_LSB = 7;
    localparam int FPEXC_RC_LSB   = 13;
    localparam int FPEXC_RC_W     = 2;
    localparam int FPEXC_NUM_EXC  = 6;

    // exception bit order inside the flag and mask groups
    localparam int FPEXC_B_INV = 0;
    localparam int FPEXC_B_DEN = 1;
    localparam int FPEXC_B_ZDV = 2;
    localparam int FPEXC_B_OVF = 3;
    localparam int FPEXC_B_UNF = 4;
    localparam int FPEXC_B_PRC = 5;

    // reset values: all masked, no flags, round to nearest
    localparam logic [5:0]  FPEXC_MASK_RST = 6'h3F;
    localparam logic [5:0]  FPEXC_FLAG_RST = 6'h00;
    localparam logic [31:0] FPEXC_ZERO32   = 32'h0000_0000;

    // result formats
    localparam logic [1:0] FPEXC_FMT_SINGLE = 2'h0;
    localparam logic [1:0] FPEXC_FMT_DOUBLE = 2'h1;
    localparam logic [1:0] FPEXC_FMT_EXT    = 2'h2;

    // unbiased exponent thresholds per format (magnitude 1.0 * 2^e)
    localparam logic signed [17:0] FPEXC_OVF_SGL = 18'sd128;
    localparam logic signed [17:0] FPEXC_OVF_DBL = 18'sd1024;
    localparam logic signed [17:0] FPEXC_OVF_EXT = 18'sd16384;
    localparam logic signed [17:0] FPEXC_TNY_SGL = -18'sd126;
    localparam logic signed [17:0] FPEXC_TNY_DBL = -18'sd1022;
    localparam logic signed [17:0] FPEXC_TNY_EXT = -18'sd16382;

    // rounding control field codes
    typedef enum logic [1:0] {
        FPEXC_RND_NEAREST = 2'h0,
        FPEXC_RND_DOWN    = 2'h1,
        FPEXC_RND_UP      = 2'h2,
        FPEXC_RND_ZERO    = 2'h3
    } fpexc_rnd_t;

    // result selection told back to the datapath
    typedef enum logic [2:0] {
        FPEXC_RES_ROUNDED,    // normal rounded result
        FPEXC_RES_QNAN,       // indefinite / quiet nan
        FPEXC_RES_INF,        // infinity, sign in res_sign
        FPEXC_RES_MAXFIN,     // largest finite, sign in res_sign
        FPEXC_RES_DENORM,     // denormalized result
        FPEXC_RES_BIASED,     // biased exponent result
        FPEXC_RES_NONE        // destination and sources untouched
    } fpexc_res_t;

    // operation as presented by the datapath
    typedef struct packed {
        logic             valid;
        logic             is_div;        // divide operation
        logic             is_store;      // floating-point store to memory
        logic             is_stack;      // legacy stack unit (else packed simd)
        logic [1:0]       fmt;
        logic             invalid_op;    // invalid arithmetic operand seen
        logic             a_denorm;
        logic             b_denorm;
        logic             a_zero;
        logic             a_finite;
        logic             b_zero;
        logic             a_sign;
        logic             b_sign;
        logic             res_sign;      // sign of the true result
        logic             res_zero;      // rounded result is zero
        logic signed [17:0] res_exp;     // unbiased exponent of rounded result
        logic             res_inexact;
    } fpexc_op_t;

    // response handed back to the datapath
    typedef struct packed {
        logic       valid;
        fpexc_res_t res_sel;
        logic       res_sign;
        logic       trap_req;
        logic       clr_cc1;   // clear condition-code bit one
        logic [5:0] raised;    // exceptions reported for this operation
    } fpexc_rsp_t;
endpackage
`default_nettype wire

/* File: sim/fpexc_unit_monitor.sv */
// checker for the exception unit, bound onto its top ports
// assumes software changes masks only between operations
`default_nettype none
// ==========================================================
// fpexc_unit_monitor
module fpexc_unit_monitor
    import fpexc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic              I_CLK,
    input wire logic              I_SYS_RST,
    input wire fpexc_op_t         I_OP,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [31:0]       I_WDATA,
    input wire logic              I_WR,
    input wire logic              I_RD,
    input wire logic [31:0]       O_RDATA,
    input wire fpexc_rsp_t        O_RSP,
    input wire logic [1:0]        O_ROUND_MODE,
    input wire logic [5:0]        O_FLAGS,
    input wire logic              O_TRAP_REQ
);
    logic [5:0] mask;
    logic [1:0] rc;
    logic       plain;
    // shadow of masks and rounding field, updated by csr writes
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            mask <= FPEXC_MASK_RST;
            rc   <= 2'h0;
        end else if (I_WR && I_ADDR == ADDR_W'(FPEXC_ADDR_CSR)) begin
            mask <= I_WDATA[12:7];
            rc   <= I_WDATA[14:13];
        end
    end
    // single-format op free of pre-computation exceptions
    assign plain = I_OP.valid && !I_OP.invalid_op && !I_OP.a_denorm && !I_OP.b_denorm
        && !I_OP.b_zero && !I_OP.res_zero && I_OP.fmt == FPEXC_FMT_SINGLE;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_trap_from_masks: assert property (
        O_RSP.valid |-> O_TRAP_REQ == |(O_RSP.raised & ~$past(mask))) else $error("bad trap");
    a_flags_sticky: assert property (
        !I_WR |=> (O_FLAGS & $past(O_FLAGS)) == $past(O_FLAGS)) else $error("flag dropped");
    a_flags_gather: assert property (
        O_RSP.valid |-> (O_FLAGS & O_RSP.raised) == O_RSP.raised) else $error("flag missing");
    a_inv_masked: assert property (
        I_OP.valid && I_OP.invalid_op && mask[0]
        |=> O_RSP.res_sel == FPEXC_RES_QNAN && O_RSP.raised[0]) else $error("no qnan");
    a_inv_unmasked: assert property (
        I_OP.valid && I_OP.invalid_op && !mask[0]
        |=> O_RSP.res_sel == FPEXC_RES_NONE && O_TRAP_REQ) else $error("invalid not trapped");
    a_zdiv_sign: assert property (
        I_OP.valid && I_OP.is_div && I_OP.b_zero && I_OP.a_finite && !I_OP.a_zero
        && !I_OP.invalid_op && !I_OP.a_denorm && !I_OP.b_denorm && mask[2]
        |=> O_RSP.res_sel == FPEXC_RES_INF && O_RSP.res_sign == ($past(I_OP.a_sign)
        ^ $past(I_OP.b_sign))) else $error("bad zero-divide result");
    a_ovf_edge: assert property (
        plain |=> O_RSP.raised[3] == ($past(I_OP.res_exp) >= FPEXC_OVF_SGL))
        else $error("overflow threshold");
    a_tiny_unmasked: assert property (
        plain && !mask[4] |=> O_RSP.raised[4] == ($past(I_OP.res_exp) < FPEXC_TNY_SGL))
        else $error("tiny not reported");
    a_unf_masked: assert property (
        plain && mask[4] |=> O_RSP.raised[4] == ($past(I_OP.res_exp) < FPEXC_TNY_SGL
        && $past(I_OP.res_inexact))) else $error("masked underflow flag");
    a_store_no_prc: assert property (
        plain && I_OP.is_store && !mask[3] && I_OP.res_exp >= FPEXC_OVF_SGL
        |=> !O_RSP.raised[5] && O_RSP.clr_cc1) else $error("store inexact reported");
    a_round_follow: assert property (
        I_WR && I_ADDR == ADDR_W'(FPEXC_ADDR_CSR) |=> O_ROUND_MODE == rc)
        else $error("rounding field");
endmodule
`default_nettype wire

/* File: sim/fpexc_dp_model.sv */
// far-side model: the execution datapath handing over one operation per request
// assumes the bench raises i_go for one cycle per operation
`default_nettype none
// ==========================================================
// fpexc_dp_model
module fpexc_dp_model
    import fpexc_pkg::*;
(
    input  wire logic      i_clk,
    input  wire logic      i_rst,
    input  wire logic      i_go,
    input  wire fpexc_op_t i_cmd,
    output var fpexc_op_t  o_op
);
    // present the op for one cycle, then scramble the idle fields
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_op <= '0;
        end else if (i_go) begin
            o_op <= i_cmd;
        end else begin
            o_op <= fpexc_op_t'({1'b0, ~o_op[$bits(fpexc_op_t)-2:0]}); // valid is the top bit
        end
    end
endmodule
`default_nettype wire

/* File: sim/fpexc_unit_tb_top.sv */
// testbench for the exception unit: table of operations, then register and reset cases
// assumes the datapath model registers each requested operation for one cycle
`default_nettype none
// ==========================================================
// fpexc_unit_tb_top
module fpexc_unit_tb_top
    import fpexc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [5:0]         m;
        logic [1:0]         rc;
        logic [6:0]         k;  // fmt, stack, store, zero divisor, denormal, invalid
        logic signed [17:0] e;
        logic               ix;
        logic               sg;
        fpexc_res_t         sel;
        logic [5:0]         rz;
        logic               tr;
    } fpexc_row_t;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, go = 0, trap;
    logic [3:0]  addr = '0;
    logic [31:0] wdata = '0, rdata, rd_val;
    fpexc_op_t   cmd = '0, op;
    fpexc_rsp_t  rsp;
    logic [1:0]  rmode;
    logic [5:0]  flags;
    int          miscompares = 0, check_count = 0;
    fpexc_row_t  rows [27] = '{
        '{6'h3F, 0, 7'h01, 0, 0, 0, FPEXC_RES_QNAN, 6'h01, 0},
        '{6'h3E, 0, 7'h01, 0, 0, 0, FPEXC_RES_NONE, 6'h01, 1},
        '{6'h3F, 0, 7'h02, 0, 0, 0, FPEXC_RES_ROUNDED, 6'h02, 0},
        '{6'h3D, 0, 7'h02, 0, 0, 0, FPEXC_RES_NONE, 6'h02, 1},
        '{6'h3F, 0, 7'h04, 0, 0, 1, FPEXC_RES_INF, 6'h04, 0},
        '{6'h3B, 0, 7'h04, 0, 0, 0, FPEXC_RES_NONE, 6'h04, 1},
        '{6'h3F, 0, 7'h00, 128, 1, 1, FPEXC_RES_INF, 6'h28, 0},
        '{6'h3F, 1, 7'h00, 128, 1, 0, FPEXC_RES_MAXFIN, 6'h28, 0},
        '{6'h3F, 1, 7'h00, 128, 1, 1, FPEXC_RES_INF, 6'h28, 0},
        '{6'h3F, 2, 7'h00, 128, 1, 0, FPEXC_RES_INF, 6'h28, 0},
        '{6'h3F, 2, 7'h00, 128, 1, 1, FPEXC_RES_MAXFIN, 6'h28, 0},
        '{6'h3F, 3, 7'h00, 128, 1, 1, FPEXC_RES_MAXFIN, 6'h28, 0},
        '{6'h3F, 0, 7'h00, 127, 0, 0, FPEXC_RES_ROUNDED, 6'h00, 0},
        '{6'h37, 0, 7'h00, 128, 1, 0, FPEXC_RES_NONE, 6'h28, 1},
        '{6'h37, 0, 7'h10, 128, 1, 0, FPEXC_RES_BIASED, 6'h28, 1},
        '{6'h3F, 0, 7'h00, -127, 0, 0, FPEXC_RES_DENORM, 6'h00, 0},
        '{6'h3F, 0, 7'h00, -127, 1, 0, FPEXC_RES_DENORM, 6'h30, 0},
        '{6'h2F, 0, 7'h00, -127, 0, 0, FPEXC_RES_NONE, 6'h10, 1},
        '{6'h2F, 0, 7'h10, -127, 0, 0, FPEXC_RES_BIASED, 6'h10, 1},
        '{6'h3F, 0, 7'h00, -126, 0, 0, FPEXC_RES_ROUNDED, 6'h00, 0},
        '{6'h3F, 0, 7'h00, 0, 1, 0, FPEXC_RES_ROUNDED, 6'h20, 0},
        '{6'h1F, 0, 7'h00, 0, 1, 0, FPEXC_RES_ROUNDED, 6'h20, 1},
        '{6'h1F, 0, 7'h00, 128, 1, 0, FPEXC_RES_INF, 6'h28, 1},
        '{6'h37, 0, 7'h08, 128, 1, 0, FPEXC_RES_NONE, 6'h08, 1},
        '{6'h3F, 0, 7'h20, 1024, 0, 0, FPEXC_RES_INF, 6'h08, 0},
        '{6'h3F, 0, 7'h40, 16383, 0, 0, FPEXC_RES_ROUNDED, 6'h00, 0},
        '{6'h3F, 0, 7'h40, -16383, 1, 0, FPEXC_RES_DENORM, 6'h30, 0}
    };
    // clock, datapath model and the unit
    always #20 clk = ~clk;
    fpexc_dp_model model (.i_clk(clk), .i_rst(rst), .i_go(go), .i_cmd(cmd), .o_op(op));
    fpexc_unit #(.ADDR_W(4)) dut (.I_CLK(clk), .I_SYS_RST(rst), .I_OP(op), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_RSP(rsp),
        .O_ROUND_MODE(rmode), .O_FLAGS(flags), .O_TRAP_REQ(trap));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one register cycle: write when w, else read, data kept in rd_val
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rd_val = rdata;
    endtask
    // hand one operation to the model, return once the response is visible
    task automatic send(input fpexc_row_t r);
        @(posedge clk);
        go <= 1'b1;
        cmd <= '{valid: 1, a_finite: 1, invalid_op: r.k[0], a_denorm: r.k[1], is_div: r.k[2],
            b_zero: r.k[2], is_store: r.k[3], is_stack: r.k[4], fmt: r.k[6:5], a_sign: r.sg,
            res_sign: r.sg, res_exp: r.e, res_inexact: r.ix, default: 0};
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence: reset values, table, then sticky, unmapped and reset cases
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, FPEXC_ADDR_CSR, 0);
        chk(rd_val, 32'h0000_1F80);
        foreach (rows[i]) begin
            bus(1, FPEXC_ADDR_CSR, {17'h0, rows[i].rc, rows[i].m, 7'h00});
            send(rows[i]);
            chk(32'({rsp.valid, rmode, rsp.res_sel, rsp.raised, trap, rsp.clr_cc1, flags}),
                32'({1'b1, rows[i].rc, rows[i].sel, rows[i].rz, rows[i].tr, rows[i].k[3],
                rows[i].rz}));
            if (rows[i].sel inside {FPEXC_RES_INF, FPEXC_RES_MAXFIN}) begin
                chk(32'(rsp.res_sign), 32'(rows[i].sg));
            end
        end
        bus(1, FPEXC_ADDR_CSR, 32'h0000_1F80);
        send(rows[0]);
        send(rows[4]);
        bus(1, 4'h5, 32'hFFFF_FFFF);
        bus(0, 4'h5, 0);
        chk(rd_val, 32'h0000_0000);
        bus(1, FPEXC_ADDR_CLEAR, 32'h0000_0001);
        bus(0, FPEXC_ADDR_CSR, 0);
        chk(rd_val, 32'h0000_1F84);
        bus(0, FPEXC_ADDR_STAT, 0);
        chk(rd_val, 32'h0000_0004);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        bus(0, FPEXC_ADDR_CSR, 0);
        chk(rd_val, 32'h0000_1F80);
        give_verdict();
    end
    // watchdog against a hung run
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule
bind fpexc_unit fpexc_unit_monitor #(.ADDR_W(ADDR_W)) mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .I_OP(I_OP), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_RSP(O_RSP), .O_ROUND_MODE(O_ROUND_MODE), .O_FLAGS(O_FLAGS),
    .O_TRAP_REQ(O_TRAP_REQ));
`default_nettype wire
